/* File: rtl/dsm_cfg.svh */
// constants of the diagnostic monitor readout register bank
`ifndef DSM_CFG_SVH
`define DSM_CFG_SVH

// register offsets on the control port
`define DSM_OFS_IN1_NEG_HIGH     8'h5c
`define DSM_OFS_IN1_NEG_LOW_ID   8'h5d
`define DSM_OFS_IN2_POS_HIGH     8'h5e
`define DSM_OFS_IN2_POS_LOW_ID   8'h5f
`define DSM_OFS_IN2_NEG_HIGH     8'h60
`define DSM_OFS_IN2_NEG_LOW_ID   8'h61
`define DSM_OFS_TEMP_HIGH        8'h6a
`define DSM_OFS_TEMP_LOW_ID      8'h6b
`define DSM_OFS_BIAS_LOAD_HIGH   8'h6c
`define DSM_OFS_BIAS_LOAD_LOW_ID 8'h6d
`define DSM_OFS_AVDD_HIGH        8'h6e
`define DSM_OFS_AVDD_LOW_ID      8'h6f
`define DSM_OFS_AUX_HIGH         8'h70
`define DSM_OFS_AUX_LOW_ID       8'h71
`define DSM_OFS_BOOST_CTRL       8'h72
`define DSM_OFS_BIAS_LEVEL_CTRL  8'h73
`define DSM_OFS_MONITOR_CTRL     8'h55

// fixed source identifiers
`define DSM_ID_IN1_NEG           4'h3
`define DSM_ID_IN2_POS           4'h4
`define DSM_ID_IN2_NEG           4'h5
`define DSM_ID_TEMP              4'ha
`define DSM_ID_BIAS_LOAD         4'hb
`define DSM_ID_AVDD              4'hc
`define DSM_ID_AUX               4'hd

// field positions
`define DSM_POS_CONVERTER_OFF    7
`define DSM_POS_BIAS_LEVEL_LSB   4
`define DSM_POS_FREEZE           0
`define DSM_POS_NIBBLE_LSB       4

// reset values and writable masks of the control registers
`define DSM_RST_RESULT_HIGH      8'h00
`define DSM_RST_BOOST_CTRL       8'h00
`define DSM_RST_BIAS_LEVEL_CTRL  8'ha0
`define DSM_RST_MONITOR_CTRL     8'h00
`define DSM_MASK_BOOST_CTRL      8'h80
`define DSM_MASK_BIAS_LEVEL_CTRL 8'hf0
`define DSM_MASK_MONITOR_CTRL    8'h01
`define DSM_UNMAPPED_READ        8'h00

`endif

/* File: rtl/dsm_pkg.sv */
// types shared by the diagnostic monitor readout register bank
package dsm_pkg;
  typedef logic [7:0]  dsm_byte_t;
  typedef logic [3:0]  dsm_nibble_t;
  typedef logic [11:0] dsm_result_t;
endpackage

/* File: rtl/dsm_cfg_byte.sv */
// one writable control byte with per-bit write mask
`timescale 1ns/1ps
`include "dsm_cfg.svh"
module dsm_cfg_byte #(
  parameter dsm_pkg::dsm_byte_t RESET_VAL = 8'h00,
  parameter dsm_pkg::dsm_byte_t WR_MASK   = 8'hff
) (
  input  wire logic               clock_in,
  input  wire logic               rst_in,
  input  wire logic               wr_en_in,
  input  wire dsm_pkg::dsm_byte_t wdata_in,
  output dsm_pkg::dsm_byte_t      value_out
);
  dsm_pkg::dsm_byte_t value_r;
  dsm_pkg::dsm_byte_t value_nxt;

  // masked bits hold their reset value, so reserved bits read back as zero
  always_comb begin
    value_nxt = value_r;
    if (wr_en_in) begin
      value_nxt = (wdata_in & WR_MASK) | (RESET_VAL & ~WR_MASK);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      value_r <= RESET_VAL;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign value_out = value_r;
endmodule // dsm_cfg_byte

/* File: rtl/dsm_result_slot.sv */
// result store of one monitored source: upper byte and lower nibble with fixed id
`timescale 1ns/1ps
`include "dsm_cfg.svh"
module dsm_result_slot #(
  parameter dsm_pkg::dsm_nibble_t SRC_ID = 4'h0
) (
  input  wire logic                 clock_in,
  input  wire logic                 rst_in,
  input  wire logic                 conv_done_in,
  input  wire dsm_pkg::dsm_nibble_t conv_source_in,
  input  wire dsm_pkg::dsm_result_t conv_data_in,
  input  wire logic                 freeze_in,
  output dsm_pkg::dsm_byte_t        high_byte_out,
  output dsm_pkg::dsm_byte_t        low_id_out
);
  dsm_pkg::dsm_result_t result_r;
  dsm_pkg::dsm_result_t result_nxt;

  // one 12-bit store keeps the byte and nibble from the same conversion
  always_comb begin
    result_nxt = result_r;
    if (conv_done_in && (conv_source_in == SRC_ID) && !freeze_in) begin // [R12] [R14]
      result_nxt = conv_data_in;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      result_r <= 12'h000;
    end else begin
      result_r <= result_nxt;
    end
  end

  assign high_byte_out = result_r[11:4]; // [R1]
  assign low_id_out    = {result_r[3:0], SRC_ID}; // [R2]
endmodule // dsm_result_slot

/* File: rtl/dsm_readout.sv */
// diagnostic monitor readout register bank with boost and bias controls
// Contract
// R1: upper result byte, read-only, resets zero
// R2: lower nibble in bits 7-4, resets zero
// R3: input2 positive id reads 0100b
// R4: input2 negative id reads 0101b
// R5: temperature id reads 1010b
// R6: bias load current id reads 1011b
// R7: analog supply id reads 1100b
// R8: aux analog input id reads 1101b
// R9: bit 7 turns converter off, reset 0
// R10: software writes zero to reserved boost bits
// R11: bias level in bits 7-4, reset 1010b
// R12: freeze bit stops result updates
// R13: reads never disturb stored values
// R14: byte and nibble update from one conversion
`timescale 1ns/1ps
`include "dsm_cfg.svh"
module dsm_readout #(
  parameter int NUM_SRC = 7
) (
  input  wire logic                 clock_in,
  input  wire logic                 rst_in,
  // control port register access
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic                 reg_wr_in,
  input  wire dsm_pkg::dsm_byte_t   reg_wdata_in,
  input  wire logic                 reg_rd_in,
  output dsm_pkg::dsm_byte_t        reg_rdata_out,
  output logic                      reg_rvalid_out,
  // monitor conversion results, same clock
  input  wire logic                 conv_done_in,
  input  wire dsm_pkg::dsm_nibble_t conv_source_in,
  input  wire dsm_pkg::dsm_result_t conv_data_in,
  // controls to the analog side
  output logic                      internal_converter_off_out,
  output dsm_pkg::dsm_nibble_t      bias_level_select_out,
  output logic                      freeze_monitor_update_out
);
  // per-source tables, index order fixed across the three tables
  localparam dsm_pkg::dsm_nibble_t SRC_ID [NUM_SRC] = '{
    `DSM_ID_IN1_NEG,
    `DSM_ID_IN2_POS, // [R3]
    `DSM_ID_IN2_NEG, // [R4]
    `DSM_ID_TEMP, // [R5]
    `DSM_ID_BIAS_LOAD, // [R6]
    `DSM_ID_AVDD, // [R7]
    `DSM_ID_AUX // [R8]
  };
  localparam logic [7:0] HIGH_OFS [NUM_SRC] = '{
    `DSM_OFS_IN1_NEG_HIGH,
    `DSM_OFS_IN2_POS_HIGH,
    `DSM_OFS_IN2_NEG_HIGH,
    `DSM_OFS_TEMP_HIGH,
    `DSM_OFS_BIAS_LOAD_HIGH,
    `DSM_OFS_AVDD_HIGH,
    `DSM_OFS_AUX_HIGH
  };
  localparam logic [7:0] LOW_OFS [NUM_SRC] = '{
    `DSM_OFS_IN1_NEG_LOW_ID,
    `DSM_OFS_IN2_POS_LOW_ID,
    `DSM_OFS_IN2_NEG_LOW_ID,
    `DSM_OFS_TEMP_LOW_ID,
    `DSM_OFS_BIAS_LOAD_LOW_ID,
    `DSM_OFS_AVDD_LOW_ID,
    `DSM_OFS_AUX_LOW_ID
  };

  dsm_pkg::dsm_byte_t high_byte   [NUM_SRC];
  dsm_pkg::dsm_byte_t low_id_byte [NUM_SRC];
  dsm_pkg::dsm_byte_t boost_ctrl;
  dsm_pkg::dsm_byte_t bias_level_ctrl;
  dsm_pkg::dsm_byte_t monitor_ctrl;
  logic               wr_boost;
  logic               wr_bias_level;
  logic               wr_monitor;
  logic               freeze;

  // write decode; result registers have no write path at all
  always_comb begin
    wr_boost      = reg_wr_in && (reg_addr_in == `DSM_OFS_BOOST_CTRL);
    wr_bias_level = reg_wr_in && (reg_addr_in == `DSM_OFS_BIAS_LEVEL_CTRL);
    wr_monitor    = reg_wr_in && (reg_addr_in == `DSM_OFS_MONITOR_CTRL);
  end

  // reserved bits are masked off, so a careless write of ones cannot stick
  dsm_cfg_byte #(
    .RESET_VAL (`DSM_RST_BOOST_CTRL),
    .WR_MASK   (`DSM_MASK_BOOST_CTRL)
  ) u_boost_ctrl (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .wr_en_in  (wr_boost), // [R9] [R10]
    .wdata_in  (reg_wdata_in),
    .value_out (boost_ctrl)
  );

  dsm_cfg_byte #(
    .RESET_VAL (`DSM_RST_BIAS_LEVEL_CTRL),
    .WR_MASK   (`DSM_MASK_BIAS_LEVEL_CTRL)
  ) u_bias_level_ctrl (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .wr_en_in  (wr_bias_level), // [R11]
    .wdata_in  (reg_wdata_in),
    .value_out (bias_level_ctrl)
  );

  dsm_cfg_byte #(
    .RESET_VAL (`DSM_RST_MONITOR_CTRL),
    .WR_MASK   (`DSM_MASK_MONITOR_CTRL)
  ) u_monitor_ctrl (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .wr_en_in  (wr_monitor),
    .wdata_in  (reg_wdata_in),
    .value_out (monitor_ctrl)
  );

  assign freeze = monitor_ctrl[`DSM_POS_FREEZE]; // [R12]

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      dsm_result_slot #(
        .SRC_ID (SRC_ID[g])
      ) u_slot (
        .clock_in       (clock_in),
        .rst_in         (rst_in),
        .conv_done_in   (conv_done_in),
        .conv_source_in (conv_source_in),
        .conv_data_in   (conv_data_in),
        .freeze_in      (freeze), // [R12]
        .high_byte_out  (high_byte[g]),
        .low_id_out     (low_id_byte[g])
      );
    end
  endgenerate

  // readback: mux is pure, a read loads only the read data and read valid registers and changes no stored value
  dsm_pkg::dsm_byte_t rdata_r;
  dsm_pkg::dsm_byte_t rdata_nxt;
  logic               rvalid_r;
  logic               rvalid_nxt;
  dsm_pkg::dsm_byte_t mux_val;

  always_comb begin
    mux_val = `DSM_UNMAPPED_READ;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (reg_addr_in == HIGH_OFS[i]) begin
        mux_val = high_byte[i]; // [R1]
      end
      if (reg_addr_in == LOW_OFS[i]) begin
        mux_val = low_id_byte[i]; // [R2]
      end
    end
    case (reg_addr_in)
      `DSM_OFS_BOOST_CTRL:      mux_val = boost_ctrl;
      `DSM_OFS_BIAS_LEVEL_CTRL: mux_val = bias_level_ctrl;
      `DSM_OFS_MONITOR_CTRL:    mux_val = monitor_ctrl;
      default:                  mux_val = mux_val;
    endcase
    rvalid_nxt = reg_rd_in;
    rdata_nxt  = reg_rd_in ? mux_val : rdata_r; // [R13]
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata_out              = rdata_r;
  assign reg_rvalid_out             = rvalid_r;
  assign internal_converter_off_out = boost_ctrl[`DSM_POS_CONVERTER_OFF]; // [R9]
  assign bias_level_select_out      = bias_level_ctrl[`DSM_POS_BIAS_LEVEL_LSB +: 4]; // [R11]
  assign freeze_monitor_update_out  = freeze;
endmodule // dsm_readout

/* File: bench/dsm_readout_assertions.sv */
// port-level checker of the monitor readout bank
`timescale 1ns/1ps
module dsm_readout_chk (
  input wire logic                 clock_in,
  input wire logic                 rst_in,
  input wire logic [7:0]           reg_addr_in,
  input wire logic                 reg_wr_in,
  input wire dsm_pkg::dsm_byte_t   reg_wdata_in,
  input wire logic                 reg_rd_in,
  input wire dsm_pkg::dsm_byte_t   reg_rdata_out,
  input wire logic                 reg_rvalid_out,
  input wire logic                 conv_done_in,
  input wire dsm_pkg::dsm_nibble_t conv_source_in,
  input wire dsm_pkg::dsm_result_t conv_data_in,
  input wire logic                 internal_converter_off_out,
  input wire dsm_pkg::dsm_nibble_t bias_level_select_out,
  input wire logic                 freeze_monitor_update_out
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  property p_id4; reg_rd_in && reg_addr_in == 8'h5f |=> reg_rdata_out[3:0] == 4'h4; endproperty
  a_id4: assert property (p_id4) else $error("id of 5f wrong");
  property p_id5; reg_rd_in && reg_addr_in == 8'h61 |=> reg_rdata_out[3:0] == 4'h5; endproperty
  a_id5: assert property (p_id5) else $error("id of 61 wrong");
  property p_ida; reg_rd_in && reg_addr_in == 8'h6b |=> reg_rdata_out[3:0] == 4'ha; endproperty
  a_ida: assert property (p_ida) else $error("id of 6b wrong");
  property p_idb; reg_rd_in && reg_addr_in == 8'h6d |=> reg_rdata_out[3:0] == 4'hb; endproperty
  a_idb: assert property (p_idb) else $error("id of 6d wrong");
  property p_idc; reg_rd_in && reg_addr_in == 8'h6f |=> reg_rdata_out[3:0] == 4'hc; endproperty
  a_idc: assert property (p_idc) else $error("id of 6f wrong");
  property p_idd; reg_rd_in && reg_addr_in == 8'h71 |=> reg_rdata_out[3:0] == 4'hd; endproperty
  a_idd: assert property (p_idd) else $error("id of 71 wrong");
  property p_off; reg_wr_in && reg_addr_in == 8'h72 |=>
    internal_converter_off_out == $past(reg_wdata_in[7]); endproperty
  a_off: assert property (p_off) else $error("converter off bit not written");
  // upper byte read right after an unfrozen conversion carries that conversion
  property p_hi; conv_done_in && conv_source_in == 4'h4 && !freeze_monitor_update_out ##1
    reg_rd_in && reg_addr_in == 8'h5e |=> reg_rdata_out == $past(conv_data_in[11:4], 2);
  endproperty
  a_hi: assert property (p_hi) else $error("upper byte not from conversion");
endmodule // dsm_readout_chk
bind dsm_readout dsm_readout_chk u_dsm_readout_chk (.*);

/* File: bench/tb.sv */
// self-checking bench of the monitor readout bank
`timescale 1ns/1ps
module tb;
  logic                 clock_in, rst_in, reg_wr_in, reg_rd_in, conv_done_in, off, frz;
  logic [7:0]           reg_addr_in;
  dsm_pkg::dsm_byte_t   reg_wdata_in, reg_rdata_out;
  logic                 reg_rvalid_out;
  dsm_pkg::dsm_nibble_t conv_source_in, bias;
  dsm_pkg::dsm_result_t conv_data_in, dat;
  int                   mismatches, comparisons;
  logic [7:0]           ofs [16] = '{8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h61, 8'h6a, 8'h6b,
                                     8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h71, 8'h72, 8'h73};
  logic [7:0]           rv [16] = '{8'h00, 8'h03, 8'h00, 8'h04, 8'h00, 8'h05, 8'h00, 8'h0a,
                                    8'h00, 8'h0b, 8'h00, 8'h0c, 8'h00, 8'h0d, 8'h00, 8'ha0};
  dsm_readout u_dsm_readout (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .conv_done_in(conv_done_in), .conv_source_in(conv_source_in),
    .conv_data_in(conv_data_in), .internal_converter_off_out(off),
    .bias_level_select_out(bias), .freeze_monitor_update_out(frz));
  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string n, dsm_pkg::dsm_byte_t s, dsm_pkg::dsm_byte_t e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  // every driver task starts and ends 1 ns after a rising edge
  task automatic wr(logic [7:0] a, dsm_pkg::dsm_byte_t v);
    reg_addr_in = a;
    reg_wdata_in = v;
    reg_wr_in = 1'b1;
    @(posedge clock_in) #1;
    reg_wr_in = 1'b0;
    // idle edge so a following write never re-raises the strobe in the same step
    @(posedge clock_in) #1;
  endtask
  task automatic rc(string n, logic [7:0] a, dsm_pkg::dsm_byte_t e);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(posedge clock_in) #1;
    reg_rd_in = 1'b0;
    for (int k = 0; reg_rvalid_out !== 1'b1; k++) begin
      if (k == 4) begin
        mismatches++;
        wrap_up();
      end
      @(posedge clock_in) #1;
    end
    chk(n, reg_rdata_out, e);
    @(posedge clock_in) #1;
  endtask
  task automatic cv(dsm_pkg::dsm_nibble_t s, dsm_pkg::dsm_result_t v);
    conv_source_in = s;
    conv_data_in = v;
    conv_done_in = 1'b1;
    @(posedge clock_in) #1;
    conv_done_in = 1'b0;
    @(posedge clock_in) #1;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 16; i++) rc("reset value", ofs[i], rv[i]);
    chk("bias out", {4'h0, bias}, 8'h0a);
    chk("off reset", {7'h0, off}, 8'h00);
    chk("freeze reset", {7'h0, frz}, 8'h00);
  endtask
  task automatic t_conv();
    for (int i = 0; i < 7; i++) begin
      dat = 12'hf31 - 12'(i) * 12'h123;
      cv(rv[2*i+1][3:0], 12'h777);
      cv(rv[2*i+1][3:0], dat);
      repeat (2) rc("upper", ofs[2*i], dat[11:4]);
      wr(ofs[2*i], 8'hff);
      wr(ofs[2*i+1], 8'hff);
      rc("lower", ofs[2*i+1], {dat[3:0], rv[2*i+1][3:0]});
      rc("upper ro", ofs[2*i], dat[11:4]);
    end
    rc("unmapped", 8'h80, 8'h00);
  endtask
  task automatic t_ctrl();
    // reserved boost bits are written as zero, as software must
    wr(8'h72, 8'h80);
    chk("off", {7'h0, off}, 8'h01);
    rc("boost", 8'h72, 8'h80);
    wr(8'h72, 8'h00);
    chk("off", {7'h0, off}, 8'h00);
    wr(8'h73, 8'h5f);
    chk("bias out", {4'h0, bias}, 8'h05);
    rc("bias", 8'h73, 8'h50);
    wr(8'h73, 8'h0f);
    chk("bias out", {4'h0, bias}, 8'h00);
  endtask
  task automatic t_freeze();
    cv(4'h4, 12'h456);
    wr(8'h55, 8'h01);
    chk("freeze", {7'h0, frz}, 8'h01);
    rc("freeze reg", 8'h55, 8'h01);
    cv(4'h4, 12'h789);
    rc("held upper", 8'h5e, 8'h45);
    rc("held lower", 8'h5f, 8'h64);
    wr(8'h55, 8'h00);
    rc("dropped", 8'h5e, 8'h45);
    cv(4'h4, 12'h789);
    rc("resumed", 8'h5e, 8'h78);
    rc("resumed lower", 8'h5f, 8'h94);
  endtask
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    {rst_in, reg_wr_in, reg_rd_in, conv_done_in} = 4'b1000;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    conv_source_in = 4'h0;
    conv_data_in = 12'h000;
    repeat (2) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
    t_reset();
    t_conv();
    t_ctrl();
    t_freeze();
    wrap_up();
  end
endmodule // tb
